// File: verilog/cgsc_regs.svh
// Purpose: named constants for the gateway subnet control block
// Assumes: 100 MHz system clock
// Notes: offsets are word indices on the plain register port
`ifndef CGSC_REGS_SVH
`define CGSC_REGS_SVH
`define CGSC_ADR_CFG 4'h0
`define CGSC_ADR_CTRL 4'h1
`define CGSC_ADR_STATUS 4'h2
`define CGSC_ADR_SILENCE 4'h3
`define CGSC_ADR_RXADR 4'h4
`define CGSC_ADR_TXADR 4'h5
`define CGSC_ADR_RXCNT 4'h6
`define CGSC_ADR_TXCNT 4'h7
`define CGSC_ADR_ALIVE0 4'h8
`define CGSC_ADR_ALIVE1 4'h9
`define CGSC_ADR_ALIVE2 4'ha
`define CGSC_ADR_ALIVE3 4'hb
`define CGSC_ADR_AUTO 16'hffff
`define CGSC_MASK_STD 29'h000007ff
`define CGSC_MASK_EXT 29'h1fffffff
`define CGSC_CFG_CSW 0
`define CGSC_CFG_START_RUN 1
`define CGSC_CFG_ALIVE_EN 2
`define CGSC_CFG_RXC_EN 3
`define CGSC_CFG_TXC_EN 4
`define CGSC_CFG_FATAL_RST 5
`define CGSC_CFG_BOFF_AUTO 6
`define CGSC_CFG_EXT_ID 7
`define CGSC_CFG_RATE_LO 8
`define CGSC_CFG_RATE_HI 11
`define CGSC_CFG_ALEN_LO 12
`define CGSC_CFG_ALEN_HI 15
`define CGSC_CTRL_INIT 0
`define CGSC_CTRL_RESTART 1
`define CGSC_CSW_BYTES 16'h0002
`define CGSC_CNT_BYTES 16'h0002
`define CGSC_RATE_MAX 4'h8
`define CGSC_MS_NS 1000000
`define CGSC_CLK_NS 10
`define CGSC_MS_CYC (`CGSC_MS_NS / `CGSC_CLK_NS)
`define CGSC_STD_ID_W 11
`endif

// File: verilog/cgsc_pkg.sv
// Purpose: types for the gateway subnet control block
// Assumes: nothing beyond the constants header
// Notes: one packed state struct
package cgsc_pkg;
  typedef enum logic [1:0] {
    CGSC_ST_INIT = 2'b00,
    CGSC_ST_RUN = 2'b01,
    CGSC_ST_IDLE = 2'b10,
    CGSC_ST_SAFE = 2'b11
  } cgsc_mode_t;
  typedef struct packed {
    logic valid;
    logic is_tx;
    logic [6:0] trn;
    logic [28:0] id;
  } cgsc_msg_t;
  typedef struct packed {
    cgsc_mode_t mode;
    logic [15:0] cfg;
    logic [15:0] silence_ms;
    logic [15:0] rx_adr;
    logic [15:0] tx_adr;
    logic [15:0] rx_cnt;
    logic [15:0] tx_cnt;
    logic [127:0] alive;
    logic [16:0] ms_div;
    logic [15:0] gap_ms;
    logic gap_busy;
    logic ctl_reset;
    logic [28:0] id_mask;
    logic [31:0] rdata;
    logic [15:0] map_status;
  } cgsc_state_t;
endpackage

// File: verilog/cgsc_top.sv
// Purpose: control, status mapping and bus parameters of a CAN gateway
// Assumes: message events come from a CAN engine on the same clock
// Notes: rx/tx address 16'hffff selects the default placement
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "cgsc_regs.svh"
module cgsc_top #(
  parameter int MS_CYCLES = `CGSC_MS_CYC,
  parameter int MAX_TRN = 128
) (
  input wire logic i_clk, // system clock
  input wire logic i_srst, // synchronous reset
  input wire logic [3:0] i_adr, // register word index
  input wire logic [31:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [31:0] o_rdata, // read data, cycle after read
  input wire cgsc_pkg::cgsc_msg_t i_msg, // completed message event
  input wire logic i_fatal, // fatal event pulse
  input wire logic i_bus_off, // controller is bus-off
  input wire logic i_tx_req, // engine wants to start a transmit
  output logic o_tx_allow, // transmit may start
  output logic o_tx_gap, // silence gap running
  output logic o_ctl_reset, // controller reset pulse
  output logic o_sys_restart, // device restart request
  output logic o_run, // subnetwork in run mode
  output logic o_safe, // locked in safe state
  output logic o_ext_id, // 29-bit identifiers in use
  output logic [28:0] o_id_mask, // identifier width mask
  output logic [3:0] o_rate_sel, // bit rate index 0..8
  output logic [15:0] o_rx_adr, // effective rx counter address
  output logic [15:0] o_tx_adr, // effective tx counter address
  output logic [15:0] o_alive_adr, // alive bitmap start address
  output logic [15:0] o_rx_cnt, // receive counter value
  output logic [15:0] o_tx_cnt, // transmit counter value
  output logic [127:0] o_alive // alive bitmap
);
  // ports are sized for the full bitmap, divider is 17 bits wide
  if (MAX_TRN != 128 || MS_CYCLES < 1 || MS_CYCLES > 131071)
  begin : g_bad_param
    $error("cgsc_top: unsupported parameter values");
  end

  cgsc_pkg::cgsc_state_t s_q;
  cgsc_pkg::cgsc_state_t s_d;
  logic csw_en;
  logic [4:0] alen;
  logic [15:0] alive_bytes;
  logic [15:0] base_adr;
  logic [15:0] rx_def;
  logic [15:0] tx_def;
  logic [15:0] rx_eff;
  logic [15:0] tx_eff;
  logic [127:0] mapped;
  logic counted;
  logic [15:0] wlo;

  assign csw_en = s_q.cfg[`CGSC_CFG_CSW];
  assign wlo = i_wdata[15:0];
  // bitmap length field n gives (n+1)*8 transactions
  assign alen = {1'b0, s_q.cfg[`CGSC_CFG_ALEN_HI:`CGSC_CFG_ALEN_LO]} + 5'h01;
  assign alive_bytes = s_q.cfg[`CGSC_CFG_ALIVE_EN] ? {11'h000, alen} : 16'h0000;
  assign base_adr = csw_en ? `CGSC_CSW_BYTES : 16'h0000;
  // lowest free address after status word and bitmap
  assign rx_def = base_adr + alive_bytes;
  assign tx_def = rx_def + (s_q.cfg[`CGSC_CFG_RXC_EN] ? `CGSC_CNT_BYTES : 16'h0000);
  assign rx_eff = (s_q.rx_adr == `CGSC_ADR_AUTO) ? rx_def : s_q.rx_adr;
  assign tx_eff = (s_q.tx_adr == `CGSC_ADR_AUTO) ? tx_def : s_q.tx_adr;

  genvar gi;
  generate
    for (gi = 0; gi < 128; gi++)
    begin : g_map
      // bit index is the transaction number
      assign mapped[gi] = s_q.cfg[`CGSC_CFG_ALIVE_EN] && (gi / 8 < alen);
    end
  endgenerate

  // any valid message event in run mode, whether its transaction number is mapped or not
  assign counted = i_msg.valid && (s_q.mode == cgsc_pkg::CGSC_ST_RUN);

  always_comb
  begin
    s_d = s_q;
    s_d.ctl_reset = 1'b0;
    s_d.rdata = 32'h00000000;
    s_d.id_mask = s_q.cfg[`CGSC_CFG_EXT_ID] ? `CGSC_MASK_EXT : `CGSC_MASK_STD;
    s_d.map_status = {13'h0000, s_q.mode == cgsc_pkg::CGSC_ST_SAFE, i_bus_off,
      s_q.mode == cgsc_pkg::CGSC_ST_RUN};
    if (i_wr)
    begin
      unique case (i_adr)
        `CGSC_ADR_CFG:
        begin
          s_d.cfg = wlo;
          if (wlo[`CGSC_CFG_RATE_HI:`CGSC_CFG_RATE_LO] > `CGSC_RATE_MAX)
          begin
            s_d.cfg[`CGSC_CFG_RATE_HI:`CGSC_CFG_RATE_LO] = s_q.cfg[`CGSC_CFG_RATE_HI:`CGSC_CFG_RATE_LO];
          end
          if (wlo[`CGSC_CFG_CSW])
          begin
            s_d.cfg[`CGSC_CFG_BOFF_AUTO] = 1'b0;
          end
        end
        `CGSC_ADR_SILENCE: s_d.silence_ms = wlo;
        `CGSC_ADR_RXADR: s_d.rx_adr = wlo;
        `CGSC_ADR_TXADR: s_d.tx_adr = wlo;
        default: ;
      endcase
    end
    if (i_rd)
    begin
      unique case (i_adr)
        `CGSC_ADR_CFG: s_d.rdata = {16'h0000, s_q.cfg};
        `CGSC_ADR_STATUS: s_d.rdata = {16'h0000, s_q.map_status};
        `CGSC_ADR_SILENCE: s_d.rdata = {16'h0000, s_q.silence_ms};
        `CGSC_ADR_RXADR: s_d.rdata = {16'h0000, rx_eff};
        `CGSC_ADR_TXADR: s_d.rdata = {16'h0000, tx_eff};
        `CGSC_ADR_RXCNT: s_d.rdata = {16'h0000, s_q.rx_cnt};
        `CGSC_ADR_TXCNT: s_d.rdata = {16'h0000, s_q.tx_cnt};
        `CGSC_ADR_ALIVE0: s_d.rdata = s_q.alive[31:0];
        `CGSC_ADR_ALIVE1: s_d.rdata = s_q.alive[63:32];
        `CGSC_ADR_ALIVE2: s_d.rdata = s_q.alive[95:64];
        `CGSC_ADR_ALIVE3: s_d.rdata = s_q.alive[127:96];
        default: s_d.rdata = 32'h00000000;
      endcase
    end
    // mode machine
    unique case (s_q.mode)
      cgsc_pkg::CGSC_ST_INIT:
      begin
        if (i_wr && i_adr == `CGSC_ADR_CTRL && i_wdata[`CGSC_CTRL_INIT])
        begin
          if (s_q.cfg[`CGSC_CFG_CSW] && !s_q.cfg[`CGSC_CFG_START_RUN])
          begin
            s_d.mode = cgsc_pkg::CGSC_ST_IDLE;
          end
          else
          begin
            s_d.mode = cgsc_pkg::CGSC_ST_RUN;
          end
        end
      end
      cgsc_pkg::CGSC_ST_RUN, cgsc_pkg::CGSC_ST_IDLE:
      begin
        if (i_wr && i_adr == `CGSC_ADR_CTRL && csw_en)
        begin
          s_d.mode = i_wdata[`CGSC_CTRL_INIT] ? cgsc_pkg::CGSC_ST_RUN : cgsc_pkg::CGSC_ST_IDLE;
        end
      end
      cgsc_pkg::CGSC_ST_SAFE:
      begin
        if (i_wr && i_adr == `CGSC_ADR_CTRL && i_wdata[`CGSC_CTRL_RESTART])
        begin
          s_d.mode = cgsc_pkg::CGSC_ST_INIT;
        end
      end
    endcase
    if (i_fatal && s_q.mode != cgsc_pkg::CGSC_ST_SAFE)
    begin
      if (s_q.cfg[`CGSC_CFG_FATAL_RST])
      begin
        // soft reset: counters, bitmap and gap cleared, restart run directly
        s_d.mode = cgsc_pkg::CGSC_ST_RUN;
        s_d.rx_cnt = 16'h0000;
        s_d.tx_cnt = 16'h0000;
        s_d.alive = '0;
        s_d.gap_busy = 1'b0;
        s_d.ctl_reset = 1'b1;
      end
      else
      begin
        s_d.mode = cgsc_pkg::CGSC_ST_SAFE;
      end
    end
    else
    begin
      if (counted && mapped[i_msg.trn])
      begin
        s_d.alive[i_msg.trn] = 1'b1;
      end
      if (counted && !i_msg.is_tx && s_q.cfg[`CGSC_CFG_RXC_EN])
      begin
        s_d.rx_cnt = s_q.rx_cnt + 16'h0001;
      end
      if (counted && i_msg.is_tx && s_q.cfg[`CGSC_CFG_TXC_EN])
      begin
        s_d.tx_cnt = s_q.tx_cnt + 16'h0001;
      end
      if (i_bus_off && s_q.cfg[`CGSC_CFG_BOFF_AUTO] && !csw_en && !s_q.ctl_reset)
      begin
        s_d.ctl_reset = 1'b1;
      end
      // silence gap counted in milliseconds after each transmit end in run mode
      if (counted && i_msg.is_tx && s_q.silence_ms != 16'h0000)
      begin
        s_d.gap_busy = 1'b1;
        s_d.gap_ms = s_q.silence_ms;
        s_d.ms_div = 17'h00000;
      end
      else if (s_q.gap_busy)
      begin
        if (s_q.ms_div == 17'(MS_CYCLES - 1))
        begin
          s_d.ms_div = 17'h00000;
          s_d.gap_ms = s_q.gap_ms - 16'h0001;
          if (s_q.gap_ms == 16'h0001)
          begin
            s_d.gap_busy = 1'b0;
          end
        end
        else
        begin
          s_d.ms_div = s_q.ms_div + 17'h00001;
        end
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      s_q <= '0;
      s_q.mode <= cgsc_pkg::CGSC_ST_INIT;
      s_q.rx_adr <= `CGSC_ADR_AUTO;
      s_q.tx_adr <= `CGSC_ADR_AUTO;
      s_q.id_mask <= `CGSC_MASK_STD;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  logic [15:0] rx_adr_q;
  logic [15:0] tx_adr_q;
  logic [15:0] alive_adr_q;
  logic tx_allow_q;
  logic restart_q;
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      rx_adr_q <= 16'h0000;
      tx_adr_q <= 16'h0000;
      alive_adr_q <= 16'h0000;
      tx_allow_q <= 1'b0;
      restart_q <= 1'b0;
    end
    else
    begin
      rx_adr_q <= rx_eff;
      tx_adr_q <= tx_eff;
      alive_adr_q <= base_adr;
      tx_allow_q <= i_tx_req && !s_d.gap_busy && s_d.mode == cgsc_pkg::CGSC_ST_RUN;
      restart_q <= i_fatal && s_q.cfg[`CGSC_CFG_FATAL_RST] &&
        s_q.mode != cgsc_pkg::CGSC_ST_SAFE;
    end
  end

  assign o_rdata = s_q.rdata;
  assign o_tx_allow = tx_allow_q;
  assign o_tx_gap = s_q.gap_busy;
  assign o_ctl_reset = s_q.ctl_reset;
  assign o_sys_restart = restart_q;
  assign o_run = s_q.map_status[0];
  assign o_safe = s_q.map_status[2];
  assign o_ext_id = s_q.cfg[`CGSC_CFG_EXT_ID];
  assign o_id_mask = s_q.id_mask;
  assign o_rate_sel = s_q.cfg[`CGSC_CFG_RATE_HI:`CGSC_CFG_RATE_LO];
  assign o_rx_adr = rx_adr_q;
  assign o_tx_adr = tx_adr_q;
  assign o_alive_adr = alive_adr_q;
  assign o_rx_cnt = s_q.rx_cnt;
  assign o_tx_cnt = s_q.tx_cnt;
  assign o_alive = s_q.alive;
endmodule

// File: tb/cgsc_top_properties.sv
// Purpose: port assertions for cgsc_top
// Assumes: bound into every cgsc_top
// Notes: sees top ports only
`timescale 1ns/1ps
module cgsc_top_properties (
  input wire logic i_clk, // clock
  input wire logic i_srst, // reset
  input wire logic i_tx_req, // transmit wish
  input wire logic o_tx_allow, // transmit may start
  input wire logic o_tx_gap, // gap running
  input wire logic o_ctl_reset, // controller reset
  input wire logic o_sys_restart, // restart pulse
  input wire logic o_run, // run mode
  input wire logic o_safe, // safe state
  input wire logic o_ext_id, // long ids
  input wire logic [28:0] o_id_mask, // id mask
  input wire logic [3:0] o_rate_sel, // rate index
  input wire logic [15:0] o_alive_adr, // bitmap start
  input wire logic [15:0] o_rx_cnt // receive count
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  a_mask_wide: assert property ($rose(o_ext_id) |-> ##[0:1] o_id_mask == 29'h1fffffff)
    else $error("mask not widened");
  a_mask_narrow: assert property ($fell(o_ext_id) |-> ##[0:1] o_id_mask == 29'h7ff)
    else $error("mask not narrowed");
  a_rx_step: assert property (o_rx_cnt != $past(o_rx_cnt) |->
    o_rx_cnt == $past(o_rx_cnt) + 16'h1 || o_rx_cnt == 16'h0)
    else $error("rx count jumped");
  a_allow_req: assert property (o_tx_allow |-> $past(i_tx_req))
    else $error("allow without request");
  a_gap_block: assert property (o_tx_gap [*2] |-> !o_tx_allow)
    else $error("allow inside gap");
  a_safe_run: assert property (o_safe |-> !o_run)
    else $error("run while safe");
  a_rate_max: assert property (o_rate_sel <= 4'h8)
    else $error("rate index out of range");
  a_restart_rst: assert property (o_sys_restart |-> o_ctl_reset)
    else $error("restart without controller reset");
  a_csw_boff: assert property (o_ctl_reset && o_alive_adr == 16'h0002 |-> o_sys_restart)
    else $error("bus-off reset with status word on");
endmodule
bind cgsc_top cgsc_top_properties chk (.i_clk, .i_srst, .i_tx_req, .o_tx_allow,
  .o_tx_gap, .o_ctl_reset, .o_sys_restart, .o_run, .o_safe, .o_ext_id, .o_id_mask,
  .o_rate_sel, .o_alive_adr, .o_rx_cnt);

// File: tb/cgsc_can_node.sv
// Purpose: other nodes on the CAN subnetwork
// Assumes: engine reports only configured traffic
// Notes: released id lines toggle
`timescale 1ns/1ps
module cgsc_can_node (
  input wire logic i_clk, // system clock
  input wire logic [28:0] i_id_mask, // id width in use
  output cgsc_pkg::cgsc_msg_t o_msg, // completed message
  output logic o_bus_off, // bus-off level
  output logic o_tx_req // transmit wish
);
  initial
  begin
    o_msg = '0;
    o_bus_off = 1'b0;
    o_tx_req = 1'b0;
  end
  task automatic send(input logic tx, input logic [6:0] trn);
    @(posedge i_clk);
    o_msg <= '{1'b1, tx, trn, 29'h1abcdef5 & i_id_mask};
    @(posedge i_clk);
    o_msg.valid <= 1'b0;
    o_msg.id <= ~o_msg.id;
  endtask
  task automatic lines(input logic bo, input logic req);
    @(posedge i_clk);
    o_bus_off <= bo;
    o_tx_req <= req;
  endtask
endmodule

// File: tb/cgsc_top_tb.sv
// Purpose: bench for cgsc_top
// Assumes: one ms shortened to 10 cycles
// Notes: register read calls carry expected values
`timescale 1ns/1ps
module cgsc_top_tb;
  logic i_clk, i_srst, i_wr, i_rd, i_fatal;
  logic [3:0] i_adr;
  logic [31:0] i_wdata, o_rdata;
  cgsc_pkg::cgsc_msg_t msg;
  logic bo, req, o_tx_allow, o_tx_gap, o_ctl_reset, o_sys_restart, o_run, o_safe, o_ext_id;
  logic [28:0] o_id_mask;
  logic [3:0] o_rate_sel;
  logic [15:0] o_rx_adr, o_tx_adr, o_alive_adr, o_rx_cnt, o_tx_cnt;
  logic [127:0] o_alive;
  int n_errors, cmp_count, n, m;
  cgsc_top #(.MS_CYCLES(10)) dut (.i_clk, .i_srst, .i_adr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_msg(msg), .i_fatal, .i_bus_off(bo), .i_tx_req(req), .o_tx_allow,
    .o_tx_gap, .o_ctl_reset, .o_sys_restart, .o_run, .o_safe, .o_ext_id, .o_id_mask,
    .o_rate_sel, .o_rx_adr, .o_tx_adr, .o_alive_adr, .o_rx_cnt, .o_tx_cnt, .o_alive);
  cgsc_can_node node (.i_clk, .i_id_mask(o_id_mask), .o_msg(msg), .o_bus_off(bo),
    .o_tx_req(req));
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_adr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_adr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk($sformatf("reg%0h", a), e, o_rdata);
  endtask
  // optional fatal pulse, then watch one output for 8 cycles
  task automatic hit(input logic f, input int k, input logic e, input string nm);
    logic s;
    s = 1'b0;
    @(posedge i_clk);
    i_fatal <= f;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge i_clk);
      i_fatal <= 1'b0;
      #1 s |= (k == 0) ? o_sys_restart : (k == 1) ? o_ctl_reset : o_safe;
    end
    chk(nm, e, s);
  endtask
  initial
  begin
    repeat (5000) @(posedge i_clk);
    n_errors++;
    end_sim;
  end
  initial
  begin
    i_srst = 1'b1;
    {i_wr, i_rd, i_fatal, i_adr, i_wdata} = '0;
    repeat (4) @(posedge i_clk);
    i_srst <= 1'b0;
    #1 chk("mask", 32'h7ff, o_id_mask);
    rd(4'h6, 32'h0);
    for (int r = 0; r < 9; r++)
    begin
      wr(4'h0, r << 8);
      chk("rate", r, o_rate_sel);
    end
    wr(4'h0, 32'h135d);
    rd(4'h0, 32'h131d);
    chk("alive_adr", 2, o_alive_adr);
    chk("rx_adr", 4, o_rx_adr);
    chk("tx_adr", 6, o_tx_adr);
    rd(4'h5, 32'h6);
    wr(4'h0, 32'h191d);
    rd(4'h0, 32'h131d);
    wr(4'h4, 32'h20);
    rd(4'h4, 32'h20);
    wr(4'h4, 32'hffff);
    rd(4'h4, 32'h4);
    $display("test map done");
    wr(4'h1, 32'h1);
    chk("run", 0, o_run);
    node.send(1'b0, 7'd3);
    rd(4'h6, 32'h0);
    wr(4'h1, 32'h1);
    chk("run", 1, o_run);
    node.send(1'b0, 7'd3);
    node.send(1'b1, 7'd15);
    node.send(1'b0, 7'd20);
    rd(4'h6, 32'h2);
    rd(4'h7, 32'h1);
    rd(4'h8, 32'h8008);
    chk("rx_cnt", 2, o_rx_cnt);
    chk("tx_cnt", 1, o_tx_cnt);
    chk("alive", 32'h8008, o_alive[31:0]);
    wr(4'h1, 32'h0);
    chk("run", 0, o_run);
    node.send(1'b0, 7'd3);
    wr(4'h1, 32'h1);
    chk("rx_cnt", 2, o_rx_cnt);
    $display("test count done");
    wr(4'h3, 32'h2);
    node.lines(1'b0, 1'b1);
    node.send(1'b1, 7'd1);
    n = 0;
    m = 0;
    for (int i = 1; i <= 40; i++)
    begin
      @(posedge i_clk);
      #1 n += o_tx_gap;
      if (o_tx_allow && m == 0)
      begin
        m = i;
      end
    end
    // 2 ms of 10 cycles; the gap rises at the counting edge, before the loop
    chk("gap", 2 * 10 - 1, n);
    chk("allow_at", 2 * 10, m);
    chk("allow", 1, o_tx_allow);
    chk("tx_cnt", 2, o_tx_cnt);
    chk("alive", 32'h800a, o_alive[31:0]);
    node.lines(1'b0, 1'b0);
    wr(4'h0, 32'h139d);
    chk("mask", 32'h1fffffff, o_id_mask);
    chk("ext_id", 1, o_ext_id);
    wr(4'h0, 32'h133d);
    chk("mask", 32'h7ff, o_id_mask);
    hit(1'b1, 0, 1'b1, "restart");
    rd(4'h6, 32'h0);
    chk("alive", 32'h0, o_alive[31:0]);
    chk("run", 1, o_run);
    wr(4'h0, 32'h131d);
    hit(1'b1, 2, 1'b1, "safe");
    repeat (10) @(posedge i_clk);
    #1 chk("safe", 1, o_safe);
    rd(4'h2, 32'h4);
    wr(4'h1, 32'h2);
    chk("safe", 0, o_safe);
    $display("test fatal done");
    node.lines(1'b1, 1'b0);
    hit(1'b0, 1, 1'b0, "csw_boff");
    rd(4'h2, 32'h2);
    wr(4'h0, 32'h40);
    rd(4'h0, 32'h40);
    node.lines(1'b1, 1'b0);
    hit(1'b0, 1, 1'b1, "ctl_reset");
    node.lines(1'b0, 1'b0);
    $display("test bus-off done");
    end_sim;
  end
endmodule
